// file: hw/xdt_decode.sv
// extended instruction decoder with cycle, length and address alu
`timescale 1ns/10ps
`include "xdt_cfg.svh"
module xdt_decode import xdt_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_in,
   output logic instr_ready_out,
   input wire logic [3:0] rep_reg_low_in,
   input wire logic [19:0] src_val_in,
   input wire logic [19:0] dst_val_in,
   output xdt_dec_s dec_out,
   output xdt_alu_s alu_out,
   output logic busy_out
);
   xdt_st_s st_q;
   xdt_st_s st_d;
   logic busy;
   logic acc;
   logic tmr_load;
   logic [5:0] tmr_count;

   assign acc = instr_valid_in && !busy;
   assign instr_ready_out = !busy;
   assign busy_out = busy;
   assign dec_out = st_q.dec;
   assign alu_out = st_q.alu;
   // single-cycle instructions never load, so intake stays open
   assign tmr_load = acc && st_d.dec.valid && (st_d.dec.cycles > 6'h1);
   assign tmr_count = st_d.dec.cycles - 6'h1;

   xdt_cycle_timer u_tmr (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .load_in(tmr_load),
      .count_in(tmr_count),
      .busy_out(busy)
   );

   always_comb begin
      logic [3:0] grp;
      logic [3:0] id;
      logic [3:0] sreg;
      logic [3:0] dreg;
      logic [1:0] as_m;
      logic [1:0] sm;
      logic [1:0] dm;
      logic [2:0] f2op;
      logic [5:0] cb;
      logic [5:0] ca;
      logic [5:0] cy;
      logic [2:0] ln;
      logic [4:0] n5;
      logic [4:0] m5;
      logic [20:0] sum;
      logic [20:0] dif;
      logic [20:0] res;
      logic vflag;
      logic arith;
      st_d = st_q;
      st_d.dec.valid = 1'b0;
      st_d.alu.flag_we = 1'b0;
      st_d.alu.dst_we = 1'b0;
      grp = instr_in[15:12];
      id = instr_in[7:4];
      sreg = instr_in[11:8];
      dreg = instr_in[3:0];
      as_m = instr_in[5:4];
      f2op = instr_in[9:7];
      cb = 6'h0;
      ca = 6'h0;
      cy = 6'h0;
      ln = 3'h1;
      sum = {1'b0, dst_val_in} + {1'b0, src_val_in};
      dif = {1'b0, dst_val_in} + {1'b0, ~src_val_in} + 21'h1;
      res = (id[1:0] == `XDT_AOP_ADD) ? sum : dif;
      // overflow: same-sign add or mixed-sign subtract flipping sign
      if (id[1:0] == `XDT_AOP_ADD) begin
         vflag = (src_val_in[19] == dst_val_in[19]) && (res[19] != dst_val_in[19]);
      end else begin
         vflag = (src_val_in[19] != dst_val_in[19]) && (res[19] != dst_val_in[19]);
      end
      arith = id[3] && (id[1:0] != `XDT_AOP_MOV);
      if (as_m == 2'h0) begin
         sm = `XDT_SM_REG;
      end else if (as_m == 2'h1) begin
         sm = `XDT_SM_IDX;
      end else if (as_m == 2'h3 && sreg == `XDT_PC_REG) begin
         sm = `XDT_SM_IMM;
      end else begin
         sm = `XDT_SM_IND;
      end
      if (instr_in[7]) begin
         dm = `XDT_DM_MEM;
      end else if (dreg == `XDT_PC_REG) begin
         dm = `XDT_DM_PC;
      end else begin
         dm = `XDT_DM_REG;
      end
      // repeat count comes from the word itself or from a register
      n5 = {1'b0, st_q.ext[7] ? rep_reg_low_in : st_q.ext[3:0]} + 5'h1;
      m5 = {1'b0, instr_in[7:4]} + 5'h1;

      if (acc) begin
         if (instr_in[15:11] == `XDT_EXT_TOP) begin
            st_d.ext = instr_in;
            st_d.fsm = XDT_S_EXT;
         end else begin
            st_d.fsm = XDT_S_IDLE;
            st_d.dec.valid = 1'b1;
            st_d.dec.cls = XDT_C_BASE;
            st_d.dec.size = XDT_Z_WORD;
            st_d.dec.rsv = 1'b0;
            st_d.dec.cycles = 6'h0;
            st_d.dec.words = 3'h1;
            case (st_q.fsm)
               XDT_S_EXT: begin
                  st_d.dec.size = xdt_size_e'({st_q.ext[6], instr_in[6]});
                  st_d.dec.rsv = ({st_q.ext[6], instr_in[6]} == 2'h0);
                  if (grp >= `XDT_GRP_FMT1) begin
                     st_d.dec.cls = XDT_C_FMT1;
                     // table by source and destination mode
                     case ({sm, dm})
                        {`XDT_SM_REG, `XDT_DM_REG}: {cb, ca, ln} = `XDT_F1_R_R;
                        {`XDT_SM_REG, `XDT_DM_PC}: {cb, ca, ln} = `XDT_F1_R_P;
                        {`XDT_SM_REG, `XDT_DM_MEM}: {cb, ca, ln} = `XDT_F1_R_M;
                        {`XDT_SM_IND, `XDT_DM_REG}: {cb, ca, ln} = `XDT_F1_I_R;
                        {`XDT_SM_IND, `XDT_DM_PC}: {cb, ca, ln} = `XDT_F1_I_P;
                        {`XDT_SM_IND, `XDT_DM_MEM}: {cb, ca, ln} = `XDT_F1_I_M;
                        {`XDT_SM_IMM, `XDT_DM_REG}: {cb, ca, ln} = `XDT_F1_N_R;
                        {`XDT_SM_IMM, `XDT_DM_PC}: {cb, ca, ln} = `XDT_F1_N_P;
                        {`XDT_SM_IMM, `XDT_DM_MEM}: {cb, ca, ln} = `XDT_F1_N_M;
                        {`XDT_SM_IDX, `XDT_DM_REG}: {cb, ca, ln} = `XDT_F1_X_R;
                        {`XDT_SM_IDX, `XDT_DM_PC}: {cb, ca, ln} = `XDT_F1_X_P;
                        default: {cb, ca, ln} = `XDT_F1_X_M;
                     endcase
                     if (dm == `XDT_DM_MEM && (grp == `XDT_OP_MOV || grp == `XDT_OP_BIT
                         || grp == `XDT_OP_CMP)) begin
                        cb = cb - `XDT_F1_ADJ_BW;
                        ca = ca - `XDT_F1_ADJ_A;
                     end
                     if (dm == `XDT_DM_PC && (sm == `XDT_SM_IMM || sm == `XDT_SM_IDX)
                         && (grp == `XDT_OP_MOV || grp == `XDT_OP_ADD
                         || grp == `XDT_OP_SUB)) begin
                        cb = cb - `XDT_F1_ADJ_PC;
                        ca = ca - `XDT_F1_ADJ_PC;
                     end
                     cy = (st_d.dec.size == XDT_Z_ADDR) ? ca : cb;
                     if (sm == `XDT_SM_REG && dm == `XDT_DM_REG) begin
                        cy = {1'b0, n5} + `XDT_REP_BASE;
                     end
                  end else if (instr_in[15:10] == `XDT_FMT2_TOP && f2op <= `XDT_F2_PUSH) begin
                     st_d.dec.cls = XDT_C_FMT2;
                     // single operand register sits in 3:0, not 11:8
                     if (as_m == 2'h3) begin
                        sm = (dreg == `XDT_PC_REG) ? `XDT_SM_IMM : `XDT_SM_IND;
                     end
                     if (f2op == `XDT_F2_PUSH) begin
                        case (sm)
                           `XDT_SM_REG: {cb, ca, ln} = `XDT_F2_PUSH_R;
                           `XDT_SM_IND: {cb, ca, ln} = `XDT_F2_PUSH_I;
                           `XDT_SM_IMM: {cb, ca, ln} = `XDT_F2_PUSH_N;
                           default: {cb, ca, ln} = `XDT_F2_PUSH_X;
                        endcase
                        if (sm == `XDT_SM_IDX && dreg == `XDT_SP_REG) begin
                           cb = cb + `XDT_SP_EXTRA;
                           ca = ca + `XDT_SP_EXTRA;
                        end
                        cy = (st_d.dec.size == XDT_Z_ADDR) ? ca : cb;
                     end else begin
                        case (sm)
                           `XDT_SM_REG: begin
                              cy = {1'b0, n5} + `XDT_REP_BASE;
                              ln = `XDT_F2_ROT_R_LEN;
                           end
                           `XDT_SM_IND: {cb, ca, ln} = `XDT_F2_ROT_I;
                           `XDT_SM_IDX: {cb, ca, ln} = `XDT_F2_ROT_X;
                           default: st_d.dec.rsv = 1'b1;
                        endcase
                        if (sm != `XDT_SM_REG) begin
                           cy = (st_d.dec.size == XDT_Z_ADDR) ? ca : cb;
                        end
                     end
                  end else begin
                     // prefix before a non-extendable word is flagged, not run
                     st_d.dec.rsv = 1'b1;
                  end
               end
               XDT_S_IDLE: begin
                  if (grp == `XDT_GRP_ADDR) begin
                     if (id[3:1] == `XDT_AID_ROTM) begin
                        // n-1 in 11:10, width in bit 4
                        st_d.dec.cls = XDT_C_ROTM;
                        st_d.dec.size = id[0] ? XDT_Z_WORD : XDT_Z_ADDR;
                        cy = {4'h0, instr_in[11:10]} + 6'h1;
                        ln = `XDT_ROTM_LEN;
                     end else begin
                        st_d.dec.cls = XDT_C_ADDR;
                        st_d.dec.size = XDT_Z_ADDR;
                        case (id[3:2])
                           2'h0: {cb, ca, ln} = id[1] ? `XDT_A_ABS : `XDT_A_IND;
                           2'h1: {cb, ca, ln} = `XDT_A_ST;
                           2'h2: begin
                              if (id[1:0] == `XDT_AOP_MOV) begin
                                 {cb, ca, ln} = `XDT_A_MIMM;
                              end else begin
                                 {cb, ca, ln} = `XDT_A_AIMM;
                              end
                           end
                           default: {cb, ca, ln} = `XDT_A_RR;
                        endcase
                        cy = (dreg == `XDT_PC_REG && id[3:2] != 2'h1) ? ca : cb;
                        if (arith) begin
                           st_d.alu.flag_we = 1'b1;
                           st_d.alu.vnzc = {vflag, res[19], res[19:0] == 20'h0, res[20]};
                        end
                        st_d.alu.result = arith ? res[19:0] : src_val_in;
                        if (id[3]) begin
                           st_d.alu.dst_we = id[1:0] != `XDT_AOP_CMP;
                        end else begin
                           st_d.alu.dst_we = id[3:2] == 2'h0;
                        end
                     end
                  end else if (instr_in[15:8] == `XDT_CALL_TOP) begin
                     st_d.dec.cls = XDT_C_CALL;
                     st_d.dec.size = XDT_Z_ADDR;
                     case (id)
                        `XDT_CID_REG: {cy, ln} = `XDT_C_REG;
                        `XDT_CID_IDX: begin
                           {cy, ln} = `XDT_C_IDX;
                           if (dreg == `XDT_SP_REG) begin
                              cy = cy + `XDT_SP_EXTRA;
                           end
                        end
                        `XDT_CID_IND: {cy, ln} = `XDT_C_IND;
                        `XDT_CID_AINC: {cy, ln} = `XDT_C_IND;
                        `XDT_CID_ABS: {cy, ln} = `XDT_C_ABS;
                        `XDT_CID_SYM: {cy, ln} = `XDT_C_ABS;
                        `XDT_CID_IMM: {cy, ln} = `XDT_C_IMM;
                        `XDT_CID_RET: st_d.dec.cls = XDT_C_BASE;
                        default: st_d.dec.rsv = 1'b1;
                     endcase
                  end else if (instr_in[15:10] == `XDT_MULT_TOP) begin
                     // count in 7:4, 20-bit takes two slots
                     st_d.dec.cls = instr_in[9] ? XDT_C_STACK_LOAD_MULTIPLE : XDT_C_STACK_STORE_MULTIPLE;
                     st_d.dec.size = instr_in[8] ? XDT_Z_WORD : XDT_Z_ADDR;
                     if (instr_in[8]) begin
                        cy = `XDT_PM_BASE + {1'b0, m5};
                     end else begin
                        cy = `XDT_PM_BASE + {m5, 1'b0};
                     end
                     ln = `XDT_PM_LEN;
                  end
               end
               default: st_d.fsm = XDT_S_IDLE;
            endcase
            st_d.dec.cycles = cy;
            st_d.dec.words = ln;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '{fsm: XDT_S_IDLE, ext: 16'h0, dec: '0, alu: '0};
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb_main @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   logic plain;
   logic a_addr;
   assign plain = acc && st_q.fsm == XDT_S_IDLE && instr_in[15:11] != `XDT_EXT_TOP;
   assign a_addr = plain && instr_in[15:12] == `XDT_GRP_ADDR && instr_in[7:5] != 3'h2;

   sequence s_ext_bw;
      acc && instr_in[15:11] == `XDT_EXT_TOP && instr_in[6];
   endsequence
   sequence s_ind_reg;
      acc && instr_in[15:12] >= `XDT_GRP_FMT1 && instr_in[5:4] == 2'h2 && !instr_in[7]
         && instr_in[3:0] != 4'h0 && !instr_in[6] && st_q.fsm == XDT_S_EXT && st_q.ext[6];
   endsequence
   sequence s_take3;
      acc && st_d.dec.valid && st_d.dec.cycles == 6'h3;
   endsequence

   a_move_flag_keep: assert property (
      a_addr && !(instr_in[7] && instr_in[5:4] != 2'h0) |=> !alu_out.flag_we)
      else $error("address move changed flags");
   a_arith_flag_set: assert property (
      a_addr && instr_in[7] && instr_in[5:4] != 2'h0 |=> alu_out.flag_we
         && alu_out.vnzc[2] == alu_out.result[19]
         && alu_out.vnzc[1] == (alu_out.result == 20'h0))
      else $error("address arithmetic flags wrong");
   a_cmp_no_write: assert property (
      a_addr && instr_in[7] && instr_in[5:4] == 2'h1 |=> !alu_out.dst_we && alu_out.flag_we)
      else $error("address compare wrote back");
   a_regreg_timing: assert property (
      a_addr && instr_in[7:6] == 2'h3 && instr_in[3:0] != 4'h0
         |=> dec_out.valid && dec_out.cycles == 6'h1 && dec_out.words == 3'h1)
      else $error("register address op timing wrong");
   a_imm_timing: assert property (
      a_addr && instr_in[7:6] == 2'h2 && instr_in[3:0] != 4'h0 |=> dec_out.words == 3'h2
         && dec_out.cycles == (($past(instr_in[5:4]) == 2'h0) ? 6'h2 : 6'h3))
      else $error("immediate address op timing wrong");
   a_call_reg: assert property (
      plain && instr_in[15:4] == 12'h134 |=> dec_out.cycles == 6'h5 && dec_out.words == 3'h1)
      else $error("register call timing wrong");
   a_stack_store_multiple_word: assert property (
      plain && instr_in[15:8] == 8'h15
         |=> dec_out.cycles == 6'h3 + {2'h0, $past(instr_in[7:4])})
      else $error("word multi push timing wrong");
   a_ext_silent: assert property (
      acc && instr_in[15:11] == `XDT_EXT_TOP |=> !dec_out.valid && st_q.fsm == XDT_S_EXT)
      else $error("extension word was decoded");
   a_ind_fmt1: assert property (
      s_ext_bw ##[1:8] s_ind_reg |=> dec_out.cycles == 6'h3 && dec_out.words == 3'h2)
      else $error("indirect format-I timing wrong");
   a_busy_span: assert property (
      s_take3 |=> !instr_ready_out [*2] ##1 instr_ready_out)
      else $error("three-cycle stall span wrong");
endmodule

// file: common/xdt_cfg.svh
// constants for the extended instruction decode and cycle timing block
`ifndef XDT_CFG_SVH
`define XDT_CFG_SVH
// What this block does
// - address add, compare, subtract update all flags
// - address move never touches status flags
// - cycles follow format and modes, main clock
// - repeated instruction takes n plus one cycles
// - byte/word memory copy, test, compare: one less
// - 20-bit memory copy, test, compare: two less
// - pc from imm/indexed: copy, add, sub one less
// - indexed call/push via stack pointer: one more
// - indirect to register: 3/4 cycles, 2 words
// - indexed to register: 4/5 cycles, 3 words
// - register-register address ops: 1 cycle (3 to pc), 1 word
// - immediate address ops: move 2 (3 to pc), others 3
// - 20-bit call: 5/1, 6/1 indirect, 5/2 immediate
// - byte/word extended push: 4 cycles (5 indexed), 2/3 words
// - byte/word arith rotate: 1+n register, 4 indirect
// - address group is top nibble zero, fields fixed
// - identifiers 10xx immediate, 11xx register forms
// - multi rotate: count, type, width fields
// - 20-bit call upper byte and mode field
// - multi push/pop: upper byte, count, register
// - 18xx to 1Fxx are extension words only
// - length bit with byte/word bit picks size
`define XDT_EXT_TOP 5'h03
`define XDT_FMT2_TOP 6'h04
`define XDT_MULT_TOP 6'h05
`define XDT_CALL_TOP 8'h13
`define XDT_GRP_ADDR 4'h0
`define XDT_GRP_FMT1 4'h4
`define XDT_OP_MOV 4'h4
`define XDT_OP_ADD 4'h5
`define XDT_OP_SUB 4'h8
`define XDT_OP_CMP 4'h9
`define XDT_OP_BIT 4'hB
`define XDT_F2_PUSH 3'h4
`define XDT_F2_ROT_MAX 3'h3
`define XDT_PC_REG 4'h0
`define XDT_SP_REG 4'h1
`define XDT_SM_REG 2'h0
`define XDT_SM_IND 2'h1
`define XDT_SM_IMM 2'h2
`define XDT_SM_IDX 2'h3
`define XDT_DM_REG 2'h0
`define XDT_DM_PC 2'h1
`define XDT_DM_MEM 2'h2
`define XDT_AOP_MOV 2'h0
`define XDT_AOP_CMP 2'h1
`define XDT_AOP_ADD 2'h2
`define XDT_AID_ROTM 3'h2
`define XDT_CID_RET 4'h0
`define XDT_CID_REG 4'h4
`define XDT_CID_IDX 4'h5
`define XDT_CID_IND 4'h6
`define XDT_CID_AINC 4'h7
`define XDT_CID_ABS 4'h8
`define XDT_CID_SYM 4'h9
`define XDT_CID_IMM 4'hB
`define XDT_F1_R_R {6'h02, 6'h02, 3'h2}
`define XDT_F1_R_P {6'h04, 6'h04, 3'h2}
`define XDT_F1_R_M {6'h05, 6'h07, 3'h3}
`define XDT_F1_I_R {6'h03, 6'h04, 3'h2}
`define XDT_F1_I_P {6'h05, 6'h06, 3'h2}
`define XDT_F1_I_M {6'h06, 6'h09, 3'h3}
`define XDT_F1_N_R {6'h03, 6'h03, 3'h3}
`define XDT_F1_N_P {6'h04, 6'h04, 3'h3}
`define XDT_F1_N_M {6'h06, 6'h08, 3'h4}
`define XDT_F1_X_R {6'h04, 6'h05, 3'h3}
`define XDT_F1_X_P {6'h06, 6'h07, 3'h3}
`define XDT_F1_X_M {6'h07, 6'h0A, 3'h4}
`define XDT_F1_ADJ_BW 6'h01
`define XDT_F1_ADJ_A 6'h02
`define XDT_F1_ADJ_PC 6'h01
`define XDT_F2_PUSH_R {6'h04, 6'h05, 3'h2}
`define XDT_F2_PUSH_I {6'h04, 6'h06, 3'h2}
`define XDT_F2_PUSH_N {6'h04, 6'h05, 3'h3}
`define XDT_F2_PUSH_X {6'h05, 6'h07, 3'h3}
`define XDT_F2_ROT_I {6'h04, 6'h06, 3'h2}
`define XDT_F2_ROT_X {6'h05, 6'h07, 3'h3}
`define XDT_F2_ROT_R_LEN 3'h2
`define XDT_SP_EXTRA 6'h01
`define XDT_REP_BASE 6'h01
`define XDT_A_IND {6'h03, 6'h05, 3'h1}
`define XDT_A_ABS {6'h04, 6'h06, 3'h2}
`define XDT_A_ST {6'h04, 6'h04, 3'h2}
`define XDT_A_MIMM {6'h02, 6'h03, 3'h2}
`define XDT_A_AIMM {6'h03, 6'h03, 3'h2}
`define XDT_A_RR {6'h01, 6'h03, 3'h1}
`define XDT_ROTM_LEN 3'h1
`define XDT_C_REG {6'h05, 3'h1}
`define XDT_C_IDX {6'h05, 3'h2}
`define XDT_C_IND {6'h06, 3'h1}
`define XDT_C_ABS {6'h07, 3'h2}
`define XDT_C_IMM {6'h05, 3'h2}
`define XDT_PM_BASE 6'h02
`define XDT_PM_LEN 3'h1
`endif

// file: common/xdt_pkg.sv
// types of the extended instruction decode and cycle timing block
package xdt_pkg;
   typedef enum logic [1:0] {XDT_S_IDLE = 2'h1, XDT_S_EXT = 2'h2} xdt_fsm_e;
   typedef enum logic [3:0] {
      XDT_C_NONE = 4'h0,
      XDT_C_ADDR = 4'h1,
      XDT_C_ROTM = 4'h2,
      XDT_C_CALL = 4'h3,
      XDT_C_STACK_STORE_MULTIPLE = 4'h4,
      XDT_C_STACK_LOAD_MULTIPLE = 4'h5,
      XDT_C_FMT1 = 4'h6,
      XDT_C_FMT2 = 4'h7,
      XDT_C_BASE = 4'h8
   } xdt_cls_e;
   typedef enum logic [1:0] {
      XDT_Z_RSV = 2'h0,
      XDT_Z_ADDR = 2'h1,
      XDT_Z_WORD = 2'h2,
      XDT_Z_BYTE = 2'h3
   } xdt_size_e;
   typedef struct packed {
      logic valid;
      xdt_cls_e cls;
      xdt_size_e size;
      logic rsv;
      logic [5:0] cycles;
      logic [2:0] words;
   } xdt_dec_s;
   typedef struct packed {
      logic [19:0] result;
      logic [3:0] vnzc;
      logic flag_we;
      logic dst_we;
   } xdt_alu_s;
   typedef struct packed {
      xdt_fsm_e fsm;
      logic [15:0] ext;
      xdt_dec_s dec;
      xdt_alu_s alu;
   } xdt_st_s;
   typedef struct packed {
      logic [5:0] cnt;
   } xdt_tmr_s;
endpackage

// file: hw/xdt_cycle_timer.sv
// execution cycle down-counter that stalls instruction intake
`timescale 1ns/10ps
`include "xdt_cfg.svh"
module xdt_cycle_timer import xdt_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic load_in,
   input wire logic [5:0] count_in,
   output logic busy_out
);
   xdt_tmr_s st_q;
   xdt_tmr_s st_d;

   always_comb begin
      st_d = st_q;
      if (load_in) begin
         st_d.cnt = count_in;
      end else if (st_q.cnt != 6'h0) begin
         st_d.cnt = st_q.cnt - 6'h1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy_out = st_q.cnt != 6'h0;
endmodule

// file: dv/xdt_fetch_model.sv
// fetch-side model that offers one instruction word at a time
`timescale 1ns/10ps
module xdt_fetch_model (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic ready_in,
   input wire logic load_in,
   input wire logic [15:0] word_in,
   output logic valid_out,
   output logic [15:0] instr_out,
   output logic taken_out
);
   // word held until an edge samples ready high
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         valid_out <= 1'h0;
         instr_out <= 16'h0;
         taken_out <= 1'h0;
      end else begin
         taken_out <= valid_out && ready_in;
         if (load_in) begin
            valid_out <= 1'h1;
            instr_out <= word_in;
         end else if (valid_out && ready_in) begin
            valid_out <= 1'h0;
            // released bus shows junk, not the old word
            instr_out <= ~instr_out;
         end
      end
   end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the extended instruction decoder
`timescale 1ns/10ps
module tb_top import xdt_pkg::*;;
   logic clk, rst_n, ld, vld, tkn, rdy, bsy;
   logic [15:0] wd, ins;
   logic [3:0] rep;
   logic [19:0] sv, dv;
   xdt_dec_s dec;
   xdt_alu_s alu;
   int miscompares = 0;
   int checked = 0;
   int i;
   xdt_decode uut (.sys_clk_in(clk), .arst_n_in(rst_n), .instr_valid_in(vld),
      .instr_in(ins), .instr_ready_out(rdy), .rep_reg_low_in(rep), .src_val_in(sv),
      .dst_val_in(dv), .dec_out(dec), .alu_out(alu), .busy_out(bsy));
   xdt_fetch_model u_mem (.sys_clk_in(clk), .arst_n_in(rst_n), .ready_in(rdy),
      .load_in(ld), .word_in(wd), .valid_out(vld), .instr_out(ins), .taken_out(tkn));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (e !== g) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // v n z c and result of add, compare, subtract
   function automatic logic [23:0] af(input logic [1:0] k, input logic [19:0] s, d);
      logic [20:0] r;
      logic v;
      r = (k == 2'h2) ? {1'h0, s} + {1'h0, d} : {1'h0, d} + {1'h0, ~s} + 21'h1;
      v = (k == 2'h2) ? (s[19] == d[19] && r[19] != s[19]) : (s[19] != d[19] && r[19] != d[19]);
      return {v, r[19], r[19:0] == 20'h0, r[20], r[19:0]};
   endfunction
   task automatic put(input logic [15:0] w, input logic [19:0] s, d);
      int k;
      @(posedge clk);
      ld <= 1'h1;
      wd <= w;
      sv <= s;
      dv <= d;
      rep <= 4'($urandom());
      @(posedge clk);
      ld <= 1'h0;
      for (k = 0; k < 40 && !tkn; k++) begin
         @(posedge clk);
         #1;
      end
      if (tkn !== 1'h1) begin
         miscompares++;
         test_done;
      end
   endtask
   task automatic ext(input logic [15:0] w);
      put(w, 20'h0, 20'h0);
      chk("prefix valid", 0, dec.valid);
   endtask
   task automatic op(input logic [15:0] w, input logic [5:0] c, input logic [2:0] n,
         input logic r, input logic [19:0] s, d);
      logic [23:0] e;
      logic [3:0] f;
      int k;
      f = alu.vnzc;
      e = af(w[5:4], s, d);
      put(w, s, d);
      chk("valid", 1, dec.valid);
      chk("rsv", r, dec.rsv);
      if (!r) chk("cycles", c, dec.cycles);
      if (!r) chk("words", n, dec.words);
      if (!r) chk("busy", c > 6'h1, bsy);
      if (w[15:12] == 4'h0 && w[7]) begin
         chk("flag_we", w[5:4] != 2'h0, alu.flag_we);
         chk("dst_we", w[5:4] != 2'h1, alu.dst_we);
         if (w[5:4] == 2'h0) chk("keep", f, alu.vnzc);
         else if (w[6] && w[5:4] == 2'h1) chk("cmp", e[23:20], alu.vnzc);
         else if (w[6]) chk("alu", e, {alu.vnzc, alu.result});
      end
      // stall length follows the decoded cycle count
      k = 0;
      while (!rdy && k < 70) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (!r) chk("stall", (c > 6'h1) ? c - 6'h1 : 6'h0, k);
   endtask
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rst_n = 1'h0;
      ld = 1'h0;
      wd = 16'h0;
      sv = 20'h0;
      dv = 20'h0;
      rep = 4'h0;
      void'($urandom(67));
      repeat (16) @(posedge clk);
      chk("reset dec", 0, dec);
      chk("reset ready", 1, rdy);
      rst_n <= 1'h1;
      for (i = 0; i < 8; i++)
         op({8'h05, 2'h3, 2'(i), 4'h8}, 1, 1, 0, 20'($urandom()), 20'($urandom()));
      op(16'h05E8, 1, 1, 0, 20'hFFFFF, 20'h00001);
      op(16'h05D8, 1, 1, 0, 20'h80000, 20'h7FFFF);
      for (i = 0; i < 4; i++)
         op({8'h03, 2'h2, 2'(i), 4'h8}, i ? 3 : 2, 2, 0, 20'($urandom()), 20'h1);
      for (i = 0; i < 4; i++) op({4'h0, 2'h2, 2'(i), 8'h58}, 3, 1, 0, 0, 0);
      for (i = 0; i < 4; i++) op({6'h05, 2'(i), 8'h38}, i[0] ? 6 : 10, 1, 0, 0, 0);
      op(16'h1348, 5, 1, 0, 0, 0);
      chk("cls", XDT_C_CALL, dec.cls);
      op(16'h1368, 6, 1, 0, 0, 0);
      op(16'h13B8, 5, 2, 0, 0, 0);
      op(16'h1351, 6, 2, 0, 0, 0);
      op(16'h13A8, 0, 0, 1, 0, 0);
      op(16'h13C8, 0, 0, 1, 0, 0);
      ext(16'h1840);
      op(16'h5928, 3, 2, 0, 0, 0);
      chk("size", XDT_Z_WORD, dec.size);
      ext(16'h1800);
      op(16'h5968, 4, 2, 0, 0, 0);
      chk("size", XDT_Z_ADDR, dec.size);
      ext(16'h1840);
      op(16'h5918, 4, 3, 0, 0, 0);
      ext(16'h1800);
      op(16'h5958, 5, 3, 0, 0, 0);
      ext(16'h1840);
      op(16'h5988, 5, 3, 0, 0, 0);
      ext(16'h1800);
      op(16'h59C8, 7, 3, 0, 0, 0);
      ext(16'h1840);
      op(16'h4988, 4, 3, 0, 0, 0);
      ext(16'h1800);
      op(16'h49C8, 5, 3, 0, 0, 0);
      ext(16'h1840);
      op(16'h5910, 5, 3, 0, 0, 0);
      ext(16'h1800);
      op(16'h5928, 0, 0, 1, 0, 0);
      ext(16'h1840);
      op(16'h1208, 4, 2, 0, 0, 0);
      ext(16'h1840);
      op(16'h1230, 4, 3, 0, 0, 0);
      ext(16'h1840);
      op(16'h1211, 6, 3, 0, 0, 0);
      ext(16'h1840);
      op(16'h1128, 4, 2, 0, 0, 0);
      ext(16'h1843);
      op(16'h1108, 5, 2, 0, 0, 0);
      test_done;
   end
endmodule
